// file: vz_exc_unit.sv
module vz_exc_unit (
  input wire logic CLOCK_IN, // Core clock
  input wire logic RSTN_IN, // Async reset, active low
  input wire vz_pkg::instr_t INSTR_IN, // Decoded instruction
  input wire vz_pkg::mode_t MODE_IN, // Mode flags
  input wire vz_pkg::exc_req_t GUEST_SYNC_IN, // Other guest sync exception
  input wire vz_pkg::exc_req_t ROOT_SYNC_IN, // Other root sync exception
  input wire vz_pkg::exc_req_t GUEST_ASYNC_IN, // Guest async exception
  input wire vz_pkg::exc_req_t ROOT_ASYNC_IN, // Root async exception
  input wire logic [7:0] ADDR_IN, // Register address
  input wire logic [31:0] WDATA_IN, // Register write data
  input wire logic WR_IN, // Write strobe
  input wire logic RD_IN, // Read strobe
  output logic [31:0] RDATA_OUT, // Read data
  output logic EXC_VALID_OUT, // Exception taken pulse
  output logic [4:0] EXC_CODE_OUT, // Exception code
  output logic EXC_ROOT_OUT, // Taken in root
  output logic EXC_DEBUG_OUT, // Debug exception pulse
  output logic GPR_WE_OUT, // GPR write pulse
  output logic [4:0] GPR_ADDR_OUT, // GPR index
  output logic [31:0] GPR_DATA_OUT, // GPR data
  output logic IRQ_OUT // Interrupt level
);

  vz_pkg::exc_req_t guest_sync, root_sync, winner;
  logic to_root, dbg_hc, gread_ok, hc_root;
  logic [vz_pkg::NUM_EVENTS-1:0] ev;
  logic [31:0] greg_a, greg_b;
  logic [vz_pkg::GREG_IDX_W-1:0] gidx;
  logic virt_q, virt_d;
  logic [3:0] greg_idx_q, greg_idx_d;
  logic [4:0] code_q, code_d, sub_q, sub_d, dbg_q, dbg_d;
  logic gm_q, gm_d;
  logic [vz_pkg::NUM_EVENTS-1:0] stat_q, stat_d, mask_q, mask_d;
  logic [31:0] rdata_d;
  logic irq_d;
  logic exc_v_d, exc_r_d, exc_dbg_d, gwe_d;
  logic [4:0] exc_c_d, gaddr_d;
  logic [31:0] gdata_d;
  logic quiet;

  // ---------------------------------------------------------------
  // Instruction checks
  // ---------------------------------------------------------------
  // Guest register index; code field never decoded
  assign gidx = INSTR_IN.rd[3:0];

  always_comb begin
    guest_sync = GUEST_SYNC_IN;
    root_sync = ROOT_SYNC_IN;
    dbg_hc = 1'b0;
    gread_ok = 1'b0;
    hc_root = 1'b0;
    ev = '0;
    if (INSTR_IN.valid && INSTR_IN.hypervisor_call_instr) begin
      if (!MODE_IN.cp0_en) begin
        ev[vz_pkg::EV_COP_UNUSABLE] = 1'b1;
        if (MODE_IN.guest_mode) begin
          guest_sync = '{1'b1, vz_pkg::EXC_COP_UNUSABLE};
        end else begin
          root_sync = '{1'b1, vz_pkg::EXC_COP_UNUSABLE};
        end
      end else if (MODE_IN.debug_mode) begin
        dbg_hc = 1'b1;
        ev[vz_pkg::EV_HC_DEBUG] = 1'b1;
      end else if (!MODE_IN.kernel_mode) begin
        ev[vz_pkg::EV_RESV] = 1'b1;
        if (MODE_IN.guest_mode) begin
          guest_sync = '{1'b1, vz_pkg::EXC_RESV_INSTR};
        end else begin
          root_sync = '{1'b1, vz_pkg::EXC_RESV_INSTR};
        end
      end else begin
        // Always to root, no enable bit involved
        hc_root = 1'b1;
        root_sync = '{1'b1, vz_pkg::EXC_GUEST_EXIT};
        ev[vz_pkg::EV_HC_ROOT] = 1'b1;
      end
    end else if (INSTR_IN.valid && INSTR_IN.gread) begin
      if (!MODE_IN.cp0_en) begin
        ev[vz_pkg::EV_COP_UNUSABLE] = 1'b1;
        if (MODE_IN.guest_mode) begin
          guest_sync = '{1'b1, vz_pkg::EXC_COP_UNUSABLE};
        end else begin
          root_sync = '{1'b1, vz_pkg::EXC_COP_UNUSABLE};
        end
      end else if (!virt_q || MODE_IN.guest_mode) begin
        ev[vz_pkg::EV_RESV] = 1'b1;
        if (MODE_IN.guest_mode) begin
          guest_sync = '{1'b1, vz_pkg::EXC_RESV_INSTR};
        end else begin
          root_sync = '{1'b1, vz_pkg::EXC_RESV_INSTR};
        end
      end else begin
        gread_ok = 1'b1;
        ev[vz_pkg::EV_GREAD] = 1'b1;
      end
    end
  end

  // Priority between guest and root detections
  exc_prioritizer u_prio (
    .guest_sync_in(guest_sync),
    .root_sync_in(root_sync),
    .guest_async_in(GUEST_ASYNC_IN),
    .root_async_in(ROOT_ASYNC_IN),
    .winner_out(winner),
    .to_root_out(to_root)
  );

  // Guest system register storage
  guest_sysreg_file u_greg (
    .clk_in(CLOCK_IN),
    .rstn_in(RSTN_IN),
    .wr_in(WR_IN && (ADDR_IN == vz_pkg::OFS_GREG_DATA)),
    .wr_idx_in(greg_idx_q),
    .wr_data_in(WDATA_IN),
    .rd_a_idx_in(gidx),
    .rd_a_out(greg_a),
    .rd_b_idx_in(greg_idx_q),
    .rd_b_out(greg_b)
  );

  // ---------------------------------------------------------------
  // Exception and GPR outputs
  // ---------------------------------------------------------------
  always_comb begin
    exc_v_d = winner.valid && !dbg_hc;
    exc_c_d = winner.code;
    exc_r_d = to_root;
    exc_dbg_d = dbg_hc;
    gwe_d = gread_ok && !winner.valid;
    gaddr_d = INSTR_IN.rt;
    // Selected register, zero when sel is nonzero
    gdata_d = (INSTR_IN.sel == 3'h0) ? greg_a : 32'h0;
  end

  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      EXC_VALID_OUT <= 1'b0;
      EXC_CODE_OUT <= 5'h00;
      EXC_ROOT_OUT <= 1'b0;
      EXC_DEBUG_OUT <= 1'b0;
      GPR_WE_OUT <= 1'b0;
      GPR_ADDR_OUT <= 5'h00;
      GPR_DATA_OUT <= 32'h0;
    end else begin
      EXC_VALID_OUT <= exc_v_d;
      EXC_CODE_OUT <= exc_c_d;
      EXC_ROOT_OUT <= exc_r_d;
      EXC_DEBUG_OUT <= exc_dbg_d;
      GPR_WE_OUT <= gwe_d;
      GPR_ADDR_OUT <= gaddr_d;
      GPR_DATA_OUT <= gdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Root cause and debug cause state
  // ---------------------------------------------------------------
  // Another source may win over the root hypercall
  function automatic logic root_sync_other();
    return ROOT_ASYNC_IN.valid || GUEST_ASYNC_IN.valid || GUEST_SYNC_IN.valid;
  endfunction

  always_comb begin
    code_d = code_q;
    sub_d = sub_q;
    gm_d = gm_q;
    dbg_d = dbg_q;
    if (dbg_hc) begin
      dbg_d = vz_pkg::EXC_GUEST_EXIT;
    end else if (winner.valid && to_root && !MODE_IN.exception_level_flag) begin
      code_d = winner.code;
      gm_d = MODE_IN.guest_mode;
      if (hc_root && !root_sync_other()) begin
        sub_d = vz_pkg::HYPERCALL_SUBCODE;
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      code_q <= 5'h00;
      sub_q <= 5'h00;
      gm_q <= 1'b0;
      dbg_q <= 5'h00;
    end else begin
      code_q <= code_d;
      sub_q <= sub_d;
      gm_q <= gm_d;
      dbg_q <= dbg_d;
    end
  end

  // ---------------------------------------------------------------
  // Register file and interrupt
  // ---------------------------------------------------------------
  always_comb begin
    virt_d = virt_q;
    greg_idx_d = greg_idx_q;
    mask_d = mask_q;
    stat_d = stat_q;
    rdata_d = 32'h0;
    if (WR_IN) begin
      case (ADDR_IN)
        vz_pkg::OFS_CTRL: virt_d = WDATA_IN[vz_pkg::CTRL_VIRT_BIT];
        vz_pkg::OFS_INT_STAT: stat_d = stat_q & ~WDATA_IN[vz_pkg::NUM_EVENTS-1:0];
        vz_pkg::OFS_INT_MASK: mask_d = WDATA_IN[vz_pkg::NUM_EVENTS-1:0];
        vz_pkg::OFS_GREG_IDX: greg_idx_d = WDATA_IN[3:0];
        default: ;
      endcase
    end
    // Set wins over clear
    stat_d = stat_d | ev;
    if (RD_IN) begin
      case (ADDR_IN)
        vz_pkg::OFS_CTRL: rdata_d[vz_pkg::CTRL_VIRT_BIT] = virt_q;
        vz_pkg::OFS_CAUSE: begin
          rdata_d[vz_pkg::CAUSE_CODE_LSB +: 5] = code_q;
          rdata_d[vz_pkg::CAUSE_SUB_LSB +: 5] = sub_q;
          rdata_d[vz_pkg::CAUSE_GM_BIT] = gm_q;
          rdata_d[vz_pkg::CAUSE_DBG_LSB +: 5] = dbg_q;
        end
        // Hidden from guest context
        vz_pkg::OFS_CAP3: rdata_d[vz_pkg::CAP3_VIRT_BIT] = virt_q && !MODE_IN.guest_mode;
        vz_pkg::OFS_INT_STAT: rdata_d[vz_pkg::NUM_EVENTS-1:0] = stat_q;
        vz_pkg::OFS_INT_MASK: rdata_d[vz_pkg::NUM_EVENTS-1:0] = mask_q;
        vz_pkg::OFS_GREG_IDX: rdata_d[3:0] = greg_idx_q;
        vz_pkg::OFS_GREG_DATA: rdata_d = greg_b;
        default: rdata_d = 32'h0;
      endcase
    end
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      virt_q <= vz_pkg::CTRL_VIRT_RST;
      greg_idx_q <= 4'h0;
      mask_q <= '0;
      stat_q <= '0;
      RDATA_OUT <= 32'h0;
      IRQ_OUT <= 1'b0;
    end else begin
      virt_q <= virt_d;
      greg_idx_q <= greg_idx_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      RDATA_OUT <= rdata_d;
      IRQ_OUT <= irq_d;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RSTN_IN);

  assign quiet = !GUEST_SYNC_IN.valid && !ROOT_SYNC_IN.valid && !GUEST_ASYNC_IN.valid && !ROOT_ASYNC_IN.valid;

  a_hc_root_code: assert property (INSTR_IN.valid && INSTR_IN.hypervisor_call_instr && MODE_IN.cp0_en && !MODE_IN.debug_mode
    && MODE_IN.kernel_mode && !MODE_IN.exception_level_flag && quiet |=> EXC_VALID_OUT && EXC_ROOT_OUT
    && EXC_CODE_OUT == vz_pkg::EXC_GUEST_EXIT && code_q == 5'h1b && sub_q == 5'h02)
    else $error("root hypercall codes wrong");
  a_hc_gm_flag: assert property (INSTR_IN.valid && INSTR_IN.hypervisor_call_instr && MODE_IN.cp0_en && !MODE_IN.debug_mode
    && MODE_IN.kernel_mode && !MODE_IN.exception_level_flag && quiet |=> gm_q == $past(MODE_IN.guest_mode))
    else $error("guest mode flag not recorded");
  a_dbg_hc_keep: assert property (INSTR_IN.valid && INSTR_IN.hypervisor_call_instr && MODE_IN.cp0_en && MODE_IN.debug_mode
    |=> EXC_DEBUG_OUT && !EXC_VALID_OUT && dbg_q == 5'h1b && $stable(code_q) && $stable(sub_q))
    else $error("debug hypercall handling wrong");
  a_hc_cop_unusable: assert property (INSTR_IN.valid && INSTR_IN.hypervisor_call_instr && !MODE_IN.cp0_en && quiet
    |=> EXC_VALID_OUT && EXC_CODE_OUT == vz_pkg::EXC_COP_UNUSABLE)
    else $error("hypercall without cp0 not unusable");
  a_gread_data: assert property (INSTR_IN.valid && INSTR_IN.gread && !INSTR_IN.hypervisor_call_instr && MODE_IN.cp0_en && virt_q
    && !MODE_IN.guest_mode && INSTR_IN.sel == 3'h0 && quiet
    |=> GPR_WE_OUT && GPR_DATA_OUT == $past(greg_a) && GPR_ADDR_OUT == $past(INSTR_IN.rt))
    else $error("guest read data wrong");
  a_gread_guest_ri: assert property (INSTR_IN.valid && INSTR_IN.gread && !INSTR_IN.hypervisor_call_instr && MODE_IN.cp0_en
    && MODE_IN.guest_mode && quiet |=> EXC_VALID_OUT && !EXC_ROOT_OUT && !GPR_WE_OUT
    && EXC_CODE_OUT == vz_pkg::EXC_RESV_INSTR)
    else $error("guest read in guest not reserved");
  a_gread_cpu_nodata: assert property (INSTR_IN.valid && INSTR_IN.gread && !INSTR_IN.hypervisor_call_instr && !MODE_IN.cp0_en
    |=> !GPR_WE_OUT ##0 (EXC_CODE_OUT == vz_pkg::EXC_COP_UNUSABLE || !$past(quiet)))
    else $error("unusable guest read moved data");
  a_gread_novirt: assert property (INSTR_IN.valid && INSTR_IN.gread && !INSTR_IN.hypervisor_call_instr && MODE_IN.cp0_en
    && !virt_q && !MODE_IN.guest_mode && quiet |=> EXC_CODE_OUT == vz_pkg::EXC_RESV_INSTR && EXC_ROOT_OUT)
    else $error("guest read without virt not reserved");
  a_sync_guest_first: assert property (GUEST_SYNC_IN.valid && ROOT_SYNC_IN.valid && !GUEST_ASYNC_IN.valid
    && !ROOT_ASYNC_IN.valid && !dbg_hc |=> EXC_VALID_OUT && !EXC_ROOT_OUT)
    else $error("root sync beat guest sync");
  a_async_root_first: assert property (GUEST_ASYNC_IN.valid && ROOT_ASYNC_IN.valid && !dbg_hc
    |=> EXC_ROOT_OUT && EXC_CODE_OUT == $past(ROOT_ASYNC_IN.code))
    else $error("guest async beat root async");
  a_cap3_guest_zero: assert property (RD_IN && ADDR_IN == vz_pkg::OFS_CAP3
    |=> RDATA_OUT[23] == ($past(virt_q) && !$past(MODE_IN.guest_mode)))
    else $error("capability bit wrong");

  c_root_hc: cover property (EXC_VALID_OUT && EXC_CODE_OUT == vz_pkg::EXC_GUEST_EXIT);
  c_dbg_hc: cover property (EXC_DEBUG_OUT);
  c_gread: cover property (GPR_WE_OUT);
  c_irq: cover property (IRQ_OUT);

endmodule // vz_exc_unit

// file: vz_pkg.sv
package vz_pkg;

  // ---------------------------------------------------------------
  // Exception codes
  // ---------------------------------------------------------------
  localparam logic [4:0] EXC_GUEST_EXIT = 5'h1b;
  localparam logic [4:0] EXC_RESV_INSTR = 5'h0a;
  localparam logic [4:0] EXC_COP_UNUSABLE = 5'h0b;
  localparam logic [4:0] HYPERCALL_SUBCODE = 5'h02;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CAUSE = 8'h04;
  localparam logic [7:0] OFS_CAP3 = 8'h08;
  localparam logic [7:0] OFS_INT_STAT = 8'h0c;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  localparam logic [7:0] OFS_GREG_IDX = 8'h14;
  localparam logic [7:0] OFS_GREG_DATA = 8'h18;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_VIRT_BIT = 0;
  localparam logic CTRL_VIRT_RST = 1'b1;
  localparam int CAP3_VIRT_BIT = 23;
  localparam int CAUSE_CODE_LSB = 0;
  localparam int CAUSE_SUB_LSB = 8;
  localparam int CAUSE_GM_BIT = 16;
  localparam int CAUSE_DBG_LSB = 24;
  localparam int NUM_EVENTS = 5;
  localparam int EV_HC_ROOT = 0;
  localparam int EV_HC_DEBUG = 1;
  localparam int EV_RESV = 2;
  localparam int EV_COP_UNUSABLE = 3;
  localparam int EV_GREAD = 4;
  localparam int GREG_ENTRIES = 16;
  localparam int GREG_IDX_W = 4;

  // Exception request
  typedef struct packed {
    logic valid;
    logic [4:0] code;
  } exc_req_t;

  // Decoded instruction
  typedef struct packed {
    logic valid;
    logic hypervisor_call_instr;
    logic gread;
    logic [4:0] rt;
    logic [4:0] rd;
    logic [2:0] sel;
  } instr_t;

  // Core mode flags
  typedef struct packed {
    logic debug_mode;
    logic guest_mode;
    logic kernel_mode;
    logic exception_level_flag;
    logic cp0_en;
  } mode_t;

endpackage

// file: exc_prioritizer.sv
module exc_prioritizer (
  input wire vz_pkg::exc_req_t guest_sync_in, // Guest-detected synchronous
  input wire vz_pkg::exc_req_t root_sync_in, // Root-detected synchronous
  input wire vz_pkg::exc_req_t guest_async_in, // Guest-detected asynchronous
  input wire vz_pkg::exc_req_t root_async_in, // Root-detected asynchronous
  output vz_pkg::exc_req_t winner_out, // Selected exception
  output logic to_root_out // Winner is taken in root
);

  // ---------------------------------------------------------------
  // Priority: asynchronous from the outside in, synchronous inside out
  // ---------------------------------------------------------------
  always_comb begin
    winner_out = '0;
    to_root_out = 1'b0;
    if (root_async_in.valid) begin
      winner_out = root_async_in;
      to_root_out = 1'b1;
    end else if (guest_async_in.valid) begin
      winner_out = guest_async_in;
    end else if (guest_sync_in.valid) begin
      winner_out = guest_sync_in;
    end else if (root_sync_in.valid) begin
      winner_out = root_sync_in;
      to_root_out = 1'b1;
    end
  end

endmodule // exc_prioritizer

// file: guest_sysreg_file.sv
module guest_sysreg_file (
  input wire logic clk_in, // Core clock
  input wire logic rstn_in, // Async reset, active low
  input wire logic wr_in, // Write strobe
  input wire logic [vz_pkg::GREG_IDX_W-1:0] wr_idx_in, // Write index
  input wire logic [31:0] wr_data_in, // Write data
  input wire logic [vz_pkg::GREG_IDX_W-1:0] rd_a_idx_in, // Port A index
  output logic [31:0] rd_a_out, // Port A data
  input wire logic [vz_pkg::GREG_IDX_W-1:0] rd_b_idx_in, // Port B index
  output logic [31:0] rd_b_out // Port B data
);

  logic [31:0] regs_q [vz_pkg::GREG_ENTRIES];
  logic [31:0] regs_d [vz_pkg::GREG_ENTRIES];

  // ---------------------------------------------------------------
  // Per-entry storage
  // ---------------------------------------------------------------
  for (genvar i = 0; i < vz_pkg::GREG_ENTRIES; i++) begin : g_ent
    always_comb begin
      regs_d[i] = regs_q[i];
      if (wr_in && (wr_idx_in == vz_pkg::GREG_IDX_W'(i))) begin
        regs_d[i] = wr_data_in;
      end
    end
    always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        regs_q[i] <= 32'h0;
      end else begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  // Read ports
  assign rd_a_out = regs_q[rd_a_idx_in];
  assign rd_b_out = regs_q[rd_b_idx_in];

endmodule // guest_sysreg_file

// file: test_vz_exc_unit.sv
module test_vz_exc_unit;
  timeunit 1ns;
  timeprecision 1ps;

  // Expected result of one instruction or exception request
  typedef struct packed {
    logic vld;
    logic [4:0] code;
    logic root;
    logic dbg;
    logic we;
    logic [4:0] addr;
    logic [31:0] data;
  } exp_t;

  logic CLOCK_IN = 1'b0;
  logic RSTN_IN = 1'b0;
  vz_pkg::instr_t INSTR_IN = '0;
  vz_pkg::mode_t MODE_IN = '0;
  vz_pkg::exc_req_t GUEST_SYNC_IN = '0, ROOT_SYNC_IN = '0, GUEST_ASYNC_IN = '0, ROOT_ASYNC_IN = '0;
  logic [7:0] ADDR_IN = 8'h00;
  logic [31:0] WDATA_IN = 32'h0;
  logic WR_IN = 1'b0;
  logic RD_IN = 1'b0;
  logic [31:0] RDATA_OUT, GPR_DATA_OUT;
  logic EXC_VALID_OUT, EXC_ROOT_OUT, EXC_DEBUG_OUT, GPR_WE_OUT, IRQ_OUT;
  logic [4:0] EXC_CODE_OUT, GPR_ADDR_OUT;
  int miscompares = 0;
  int checks = 0;
  int seed = 14409;
  logic rd_prev = 1'b0;
  exp_t eq[$];
  logic [31:0] rq[$];
  logic [31:0] greg[4];
  logic [31:0] cause_e = 32'h0;

  vz_exc_unit uut (
    .CLOCK_IN(CLOCK_IN), .RSTN_IN(RSTN_IN), .INSTR_IN(INSTR_IN), .MODE_IN(MODE_IN),
    .GUEST_SYNC_IN(GUEST_SYNC_IN), .ROOT_SYNC_IN(ROOT_SYNC_IN), .GUEST_ASYNC_IN(GUEST_ASYNC_IN),
    .ROOT_ASYNC_IN(ROOT_ASYNC_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .RDATA_OUT(RDATA_OUT), .EXC_VALID_OUT(EXC_VALID_OUT), .EXC_CODE_OUT(EXC_CODE_OUT),
    .EXC_ROOT_OUT(EXC_ROOT_OUT), .EXC_DEBUG_OUT(EXC_DEBUG_OUT), .GPR_WE_OUT(GPR_WE_OUT),
    .GPR_ADDR_OUT(GPR_ADDR_OUT), .GPR_DATA_OUT(GPR_DATA_OUT), .IRQ_OUT(IRQ_OUT)
  );

  // ----------------------------------------
  // Clock
  // ----------------------------------------
  always #12.5 CLOCK_IN = ~CLOCK_IN;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic vz_pkg::mode_t md(logic d, logic g, logic k, logic x, logic c);
    md = '{debug_mode: d, guest_mode: g, kernel_mode: k, exception_level_flag: x, cp0_en: c};
  endfunction

  function automatic exp_t ex(logic v, logic [4:0] c, logic r, logic d, logic w, logic [4:0] a, logic [31:0] dt);
    ex = '{vld: v, code: c, root: r, dbg: d, we: w, addr: a, data: dt};
  endfunction

  // Register bus write, one strobe cycle
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK_IN);
    ADDR_IN <= a;
    WDATA_IN <= d;
    WR_IN <= 1'b1;
    @(posedge CLOCK_IN);
    WR_IN <= 1'b0;
  endtask

  // Register bus read, data checked by the monitor
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge CLOCK_IN);
    ADDR_IN <= a;
    RD_IN <= 1'b1;
    rq.push_back(e);
    @(posedge CLOCK_IN);
    RD_IN <= 1'b0;
  endtask

  // Issue one decoded instruction and note its outcome
  task automatic issue(input logic hcall, input logic [4:0] rt, input logic [4:0] rd,
                       input vz_pkg::mode_t m, input exp_t e);
    @(posedge CLOCK_IN);
    INSTR_IN <= '{valid: 1'b1, hypervisor_call_instr: hcall, gread: !hcall, rt: rt, rd: rd, sel: 3'h0};
    MODE_IN <= m;
    eq.push_back(e);
    @(posedge CLOCK_IN);
    INSTR_IN <= '0;
  endtask

  // Raise external exception requests for one cycle
  task automatic ext(input logic [5:0] gs, input logic [5:0] rs, input logic [5:0] ga,
                     input logic [5:0] ra, input exp_t e);
    @(posedge CLOCK_IN);
    GUEST_SYNC_IN <= gs;
    ROOT_SYNC_IN <= rs;
    GUEST_ASYNC_IN <= ga;
    ROOT_ASYNC_IN <= ra;
    eq.push_back(e);
    @(posedge CLOCK_IN);
    {GUEST_SYNC_IN, ROOT_SYNC_IN, GUEST_ASYNC_IN, ROOT_ASYNC_IN} <= '0;
  endtask

  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Monitor: compares outputs with the oldest note
  // ----------------------------------------
  always @(posedge CLOCK_IN) rd_prev <= RD_IN;

  always @(negedge CLOCK_IN) begin
    exp_t e;
    if (RSTN_IN === 1'b1) begin
      if ((EXC_VALID_OUT | EXC_DEBUG_OUT | GPR_WE_OUT) === 1'b1) begin
        if (eq.size() == 0) begin
          chk(32'h1, 32'h0, "unexpected result");
        end else begin
          e = eq.pop_front();
          chk({EXC_VALID_OUT, EXC_DEBUG_OUT, GPR_WE_OUT}, {e.vld, e.dbg, e.we}, "pulses");
          if (e.vld) chk({EXC_CODE_OUT, EXC_ROOT_OUT}, {e.code, e.root}, "code and root");
          if (e.we) chk({GPR_ADDR_OUT, GPR_DATA_OUT}, {e.addr, e.data}, "gpr write");
        end
      end
      if (rd_prev) chk(RDATA_OUT, rq.pop_front(), "read data");
    end
  end

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    #(25ns * 4000);
    miscompares++;
    finish_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge CLOCK_IN);
    RSTN_IN <= 1'b1;
    MODE_IN <= md(0, 0, 1, 0, 1);
    reg_rd(vz_pkg::OFS_CTRL, 32'h1);
    reg_rd(vz_pkg::OFS_CAUSE, 32'h0);
    reg_rd(vz_pkg::OFS_INT_MASK, 32'h0);
    reg_rd(8'hfc, 32'h0);
    reg_rd(vz_pkg::OFS_CAP3, 32'h0080_0000);
    // Load guest registers with random data
    for (int i = 0; i < 4; i++) begin
      greg[i] = $random(seed);
      reg_wr(vz_pkg::OFS_GREG_IDX, i);
      reg_wr(vz_pkg::OFS_GREG_DATA, greg[i]);
      reg_rd(vz_pkg::OFS_GREG_DATA, greg[i]);
    end
    // Root kernel hypercall
    issue(1, 5'h00, 5'h00, md(0, 0, 1, 0, 1), ex(1, 5'h1b, 1, 0, 0, 0, 0));
    cause_e[12:0] = 13'h021b;
    reg_rd(vz_pkg::OFS_CAUSE, cause_e);
    // Debug-mode hypercall leaves root cause alone
    issue(1, 5'h00, 5'h00, md(1, 0, 1, 0, 1), ex(0, 0, 0, 1, 0, 0, 0));
    cause_e[28:24] = 5'h1b;
    reg_rd(vz_pkg::OFS_CAUSE, cause_e);
    // Guest kernel hypercall taken in root
    issue(1, 5'h00, 5'h00, md(0, 1, 1, 0, 1), ex(1, 5'h1b, 1, 0, 0, 0, 0));
    cause_e[16] = 1'b1;
    reg_rd(vz_pkg::OFS_CAUSE, cause_e);
    reg_rd(vz_pkg::OFS_CAP3, 32'h0);
    // Hypercall with coprocessor access disabled
    issue(1, 5'h00, 5'h00, md(0, 0, 1, 0, 0), ex(1, 5'h0b, 1, 0, 0, 0, 0));
    // Guest register reads, each followed by one idle cycle
    for (int i = 0; i < 4; i++) begin
      logic [4:0] rt;
      rt = 5'($random(seed));
      issue(0, rt, 5'(i), md(0, 0, 1, 0, 1), ex(0, 0, 0, 0, 1, rt, greg[i]));
    end
    issue(0, 5'h03, 5'h01, md(0, 1, 1, 0, 1), ex(1, 5'h0a, 0, 0, 0, 0, 0));
    issue(0, 5'h03, 5'h01, md(0, 0, 1, 0, 0), ex(1, 5'h0b, 1, 0, 0, 0, 0));
    reg_wr(vz_pkg::OFS_CTRL, 32'h0);
    reg_rd(vz_pkg::OFS_CAP3, 32'h0);
    issue(0, 5'h03, 5'h01, md(0, 0, 1, 0, 1), ex(1, 5'h0a, 1, 0, 0, 0, 0));
    reg_wr(vz_pkg::OFS_CTRL, 32'h1);
    // Guest versus root priority
    ext({1'b1, 5'h04}, {1'b1, 5'h05}, 6'h00, 6'h00, ex(1, 5'h04, 0, 0, 0, 0, 0));
    ext(6'h00, {1'b1, 5'h06}, 6'h00, 6'h00, ex(1, 5'h06, 1, 0, 0, 0, 0));
    ext(6'h00, 6'h00, {1'b1, 5'h01}, {1'b1, 5'h02}, ex(1, 5'h02, 1, 0, 0, 0, 0));
    ext(6'h00, 6'h00, {1'b1, 5'h01}, 6'h00, ex(1, 5'h01, 0, 0, 0, 0, 0));
    // Interrupt: raise, mask, clear
    reg_wr(vz_pkg::OFS_INT_STAT, 32'h1f);
    reg_rd(vz_pkg::OFS_INT_STAT, 32'h0);
    issue(1, 5'h00, 5'h00, md(0, 0, 1, 0, 1), ex(1, 5'h1b, 1, 0, 0, 0, 0));
    reg_rd(vz_pkg::OFS_INT_STAT, 32'h1);
    repeat (3) @(posedge CLOCK_IN);
    chk(IRQ_OUT, 1'b0, "irq masked");
    reg_wr(vz_pkg::OFS_INT_MASK, 32'h1);
    repeat (3) @(posedge CLOCK_IN);
    chk(IRQ_OUT, 1'b1, "irq raised");
    reg_wr(vz_pkg::OFS_INT_STAT, 32'h1);
    repeat (3) @(posedge CLOCK_IN);
    chk(IRQ_OUT, 1'b0, "irq cleared");
    reg_rd(vz_pkg::OFS_INT_STAT, 32'h0);
    repeat (4) @(posedge CLOCK_IN);
    chk(eq.size() + rq.size(), 0, "pending notes");
    finish_test();
  end
endmodule // test_vz_exc_unit
